// ==== bench/pin_load.sv ====
// far-side load on one pulse pin: pull-down when the pin is not driven
// assumes one clock; reports the widths of the last low and high runs
module pin_load
(
    input wire logic ref_clk,
    input wire logic pin,
    input wire logic oe,
    output int low_w,
    output int high_w
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line;
    logic last = 1'b0;
    int run_len = 0;
    // undriven pin is pulled low by the external load
    assign line = oe ? pin : 1'b0;
    initial
    begin
        low_w = 0;
        high_w = 0;
    end
    always @(posedge ref_clk)
    begin
        if (line !== last)
        begin
            if (last)
                high_w <= run_len;
            else
                low_w <= run_len;
            run_len <= 1;
        end
        else
            run_len <= run_len + 1;
        last <= line;
    end
endmodule

// ==== bench/pulse_generator_checker.sv ====
// port-level assertions for the pulse generator
// assumes it is bound to pulse_generator, one clock domain
module pulse_gen_checker
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic timebase_tick,
    input wire logic ch0_pin_a,
    input wire logic ch0_pin_a_oe,
    input wire logic ch0_pin_b,
    input wire logic ch0_pin_b_oe,
    input wire logic ch1_pin_a,
    input wire logic ch1_pin_a_oe,
    input wire logic ch1_pin_b,
    input wire logic ch1_pin_b_oe,
    input wire logic ch0_irq,
    input wire logic ch1_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wc;
    logic wo;
    logic wr0;
    assign wc = reg_write && reg_addr == pulse_gen_pkg::addr_control;
    assign wo = reg_write && reg_addr == pulse_gen_pkg::addr_out_clk;
    assign wr0 = reg_write && reg_addr == pulse_gen_pkg::addr_ch0_reload;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_OE_A: assert property (wc |=> ch0_pin_a_oe == $past(reg_wdata[5])
        && ch1_pin_a_oe == $past(reg_wdata[13]))
        else $error("pin a enable does not follow control write");
    AST_OE_B: assert property (wo |=> ch0_pin_b_oe == $past(reg_wdata[0])
        && ch1_pin_b_oe == $past(reg_wdata[1]))
        else $error("pin b enable does not follow output register write");
    AST_OE_HOLD: assert property (!reg_write |=>
        $stable({ch0_pin_a_oe, ch0_pin_b_oe, ch1_pin_a_oe, ch1_pin_b_oe}))
        else $error("pin enable changed without a write");
    AST_STOP0: assert property (wc && !reg_wdata[pulse_gen_pkg::bit_ch0_run]
        |-> ##3 !ch0_pin_a)
        else $error("channel 0 pin not low after stop");
    AST_STOP1: assert property (wc && !reg_wdata[pulse_gen_pkg::bit_ch1_run]
        |-> ##3 !ch1_pin_a)
        else $error("channel 1 pin not low after stop");
    AST_IRQ0_OFF: assert property (wc && !reg_wdata[pulse_gen_pkg::bit_ch0_irq_en]
        |-> ##2 !ch0_irq)
        else $error("channel 0 request with its enable clear");
    AST_IRQ1_OFF: assert property (wc && !reg_wdata[pulse_gen_pkg::bit_ch1_irq_en]
        |-> ##2 !ch1_irq)
        else $error("channel 1 request with its enable clear");
    AST_RELOAD_RB: assert property (wr0 ##1
        (reg_read && reg_addr == pulse_gen_pkg::addr_ch0_reload)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reload value read back wrong");
endmodule

bind pulse_generator pulse_gen_checker chk_u (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .timebase_tick, .ch0_pin_a, .ch0_pin_a_oe,
    .ch0_pin_b, .ch0_pin_b_oe, .ch1_pin_a, .ch1_pin_a_oe, .ch1_pin_b, .ch1_pin_b_oe,
    .ch0_irq, .ch1_irq);

// ==== bench/pulse_generator_tb_top.sv ====
// self-checking bench for the pulse generator
// assumes the pin_load far-side model and a bound port checker
module pulse_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] a_ctl = pulse_gen_pkg::addr_control;
    localparam logic [3:0] a_r0 = pulse_gen_pkg::addr_ch0_reload;
    localparam logic [3:0] a_r1 = pulse_gen_pkg::addr_ch1_reload;
    localparam logic [3:0] a_oc = pulse_gen_pkg::addr_out_clk;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic timebase_tick = 1'b0;
    logic [2:0] tb_cnt = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] v;
    logic ch0_pin_a, ch0_pin_a_oe, ch0_pin_b, ch0_pin_b_oe, ch1_pin_a, ch1_pin_a_oe;
    logic ch1_pin_b, ch1_pin_b_oe, ch0_irq, ch1_irq;
    int num_errors = 0;
    int n_compared = 0;
    int w0l, w0h, w1l, w1h;

    always #2 ref_clk = ~ref_clk;
    // timebase tick: one cycle in eight
    always @(posedge ref_clk)
    begin
        tb_cnt <= tb_cnt + 3'h1;
        timebase_tick <= (tb_cnt == 3'h7);
    end

    pulse_generator dut_u (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .timebase_tick, .ch0_pin_a, .ch0_pin_a_oe, .ch0_pin_b, .ch0_pin_b_oe,
        .ch1_pin_a, .ch1_pin_a_oe, .ch1_pin_b, .ch1_pin_b_oe, .ch0_irq, .ch1_irq);
    pin_load p0 (.ref_clk, .pin(ch0_pin_a), .oe(ch0_pin_a_oe), .low_w(w0l), .high_w(w0h));
    pin_load p1 (.ref_clk, .pin(ch1_pin_b), .oe(ch1_pin_b_oe), .low_w(w1l), .high_w(w1h));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic idle(input int n);
        @(posedge ref_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (n) @(posedge ref_clk);
        // look at outputs once the edge's updates have settled
        #1;
    endtask
    task automatic chk_w(input int l, input int h, input int el, input int eh);
        check(16'(l), 16'(el));
        check(16'(h), 16'(eh));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        chk_rd(a_ctl, pulse_gen_pkg::control_reset);
        chk_rd(4'hf, 16'h0000);
        check({12'h000, ch0_pin_a, ch1_pin_a, ch0_irq, ch1_irq}, 16'h0000);
        wr(a_r0, 16'h0402);
        chk_rd(a_r0, 16'h0402);
        wr(a_r1, 16'h0001);
        chk_rd(a_r1, 16'h0001);
    endtask
    task automatic t_indep;
        wr(a_oc, 16'h0022);
        wr(a_ctl, 16'h80b0);
        idle(40);
        chk_w(w0l, w0h, 3, 5);
        chk_w(w1l, w1h, 4, 2);
        check({14'h0000, ch0_irq, ch1_irq}, 16'h0002);
        chk_rd(a_ctl, 16'h88b8);
        wr(a_ctl, 16'h0808);
        idle(3);
        check({14'h0000, ch0_pin_a, ch1_pin_b}, 16'h0000);
        rd(pulse_gen_pkg::addr_counters, v);
        idle(4);
        chk_rd(pulse_gen_pkg::addr_counters, v);
        wr(a_ctl, 16'h0000);
        chk_rd(a_ctl, 16'h0000);
        wr(a_ctl, 16'h0808);
        chk_rd(a_ctl, 16'h0000);
    endtask
    task automatic t_modes;
        wr(a_r0, 16'h0100);
        wr(a_r1, 16'h0001);
        wr(a_ctl, 16'ha6a0);
        idle(600);
        chk_w(w0l, w0h, 257, 2);
        chk_w(w1l, w1h, 257, 2);
        check({13'h0, ch0_pin_b, ch1_pin_a, ch1_pin_b}, {13'h0, {3{ch0_pin_a}}});
        chk_rd(a_ctl, 16'haea8);
        wr(a_ctl, 16'h0e08);
        wr(a_oc, 16'h0002);
        wr(a_r0, 16'h0101);
        wr(a_r1, 16'h0202);
        wr(a_ctl, 16'h82a0);
        idle(60);
        chk_w(w0l, w0h, 2, 2);
        chk_w(w1l, w1h, 6, 6);
        wr(a_ctl, 16'h0208);
        idle(2);
    endtask
    task automatic t_sel;
        logic [2:0] sel [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        int div [6] = '{1, 2, 4, 8, 16, 8};
        wr(a_r0, 16'h0000);
        foreach (sel[i])
        begin
            wr(a_oc, {11'h000, sel[i], 2'h0});
            // reserved mode code behaves as independent channels
            wr(a_ctl, 16'h04a0);
            idle(80);
            chk_w(w0l, w0h, div[i], div[i]);
            wr(a_ctl, 16'h0008);
            idle(2);
        end
        // select code 5 gives no count clock: no underflow, flag stays clear
        wr(a_oc, 16'h0014);
        wr(a_ctl, 16'h00a0);
        idle(40);
        check({15'h0000, ch0_pin_a}, 16'h0000);
        chk_rd(a_ctl, 16'h00a0);
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_indep();
        t_modes();
        t_sel();
        end_of_test();
    end
    // cuts a hang short well past the expected run of some 1300 cycles
    initial
    begin
        #40000;
        num_errors++;
        end_of_test();
    end
endmodule

// ==== hw/count_clock_select.sv ====
// count clock tick generator for one channel
// assumes a free-running prescaler count and a timebase tick from outside
module count_clock_select
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [pulse_gen_pkg::prescale_width-1:0] prescale,
    input wire logic timebase_tick,
    input wire logic [2:0] clk_sel,
    output logic tick
);
    logic [pulse_gen_pkg::prescale_width-1:0] prev;
    logic next_tick;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prev <= '0;
        else
            prev <= prescale;
    end

    // a divide-by-2^n tick fires when bit n-1 of the prescaler falls
    always_comb
    begin
        unique case (clk_sel)
            pulse_gen_pkg::sel_div1: next_tick = 1'b1;
            pulse_gen_pkg::sel_div2: next_tick = prev[0] & ~prescale[0];
            pulse_gen_pkg::sel_div4: next_tick = prev[1] & ~prescale[1];
            pulse_gen_pkg::sel_div8: next_tick = prev[2] & ~prescale[2];
            pulse_gen_pkg::sel_div16: next_tick = prev[3] & ~prescale[3];
            pulse_gen_pkg::sel_timebase: next_tick = timebase_tick;
            default: next_tick = 1'b0;
        endcase
    end

    assign tick = next_tick;
endmodule

// ==== hw/pulse_channel.sv ====
// one 8-bit reload down counter with alternate low/high reload and output toggle
// assumes the parent supplies the count tick and the start request
module pulse_channel
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [7:0] low_reload,
    input wire logic [7:0] high_reload,
    output logic [7:0] count,
    output logic level,
    output logic underflow
);
    logic running;

    // underflow is the step from zero, taken on a count tick
    assign underflow = run & running & tick & (count == 8'h00);

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= 8'h00;
            level <= 1'b0;
            running <= 1'b0;
        end
        else if (!run)
        begin
            count <= 8'h00;
            level <= 1'b0;
            running <= 1'b0;
        end
        else if (!running)
        begin
            count <= low_reload;
            level <= 1'b0;
            running <= 1'b1;
        end
        else if (underflow)
        begin
            count <= level ? low_reload : high_reload;
            level <= ~level;
        end
        else if (tick)
            count <= count - 8'h01;
    end
endmodule

// ==== hw/pulse_gen_pkg.sv ====
// constants, register map and field layout of the dual-channel pulse generator
// assumes a single 250 MHz clock domain and a plain strobe register port
package pulse_gen_pkg;

    // register index map (word addresses on the plain register port)
    localparam logic [3:0] addr_control = 4'h0;
    localparam logic [3:0] addr_ch0_reload = 4'h1;
    localparam logic [3:0] addr_ch1_reload = 4'h2;
    localparam logic [3:0] addr_out_clk = 4'h3;
    localparam logic [3:0] addr_counters = 4'h4;

    // control register fields: channel 0 in the low byte, channel 1 in the high byte
    localparam int bit_ch0_flag = 3;
    localparam int bit_ch0_irq_en = 4;
    localparam int bit_ch0_pin_a_en = 5;
    localparam int bit_ch0_run = 7;
    localparam int bit_mode_lo = 9;
    localparam int bit_mode_hi = 10;
    localparam int bit_ch1_flag = 11;
    localparam int bit_ch1_irq_en = 12;
    localparam int bit_ch1_pin_a_en = 13;
    localparam int bit_ch1_run = 15;

    // output and clock-select register fields
    localparam int bit_ch0_pin_b_en = 0;
    localparam int bit_ch1_pin_b_en = 1;
    localparam int pos_ch0_clk_sel = 2;
    localparam int pos_ch1_clk_sel = 5;

    localparam logic [15:0] control_reset = 16'h0000;
    localparam logic [7:0] out_clk_reset = 8'h00;
    localparam logic [15:0] reload_reset = 16'h0000;

    typedef enum logic [1:0] {
        mode_independent = 2'b00,
        mode_prescaled = 2'b01,
        mode_reserved = 2'b10,
        mode_cascaded = 2'b11
    } mode_t;

    // clock-select codes: machine clock divided, or the timebase tick
    localparam logic [2:0] sel_div1 = 3'h0;
    localparam logic [2:0] sel_div2 = 3'h1;
    localparam logic [2:0] sel_div4 = 3'h2;
    localparam logic [2:0] sel_div8 = 3'h3;
    localparam logic [2:0] sel_div16 = 3'h4;
    localparam logic [2:0] sel_timebase = 3'h7;

    localparam int prescale_width = 4;
endpackage

// ==== hw/pulse_generator.sv ====
// dual-channel programmable pulse generator, top level
// assumes a plain strobe register port and a timebase tick from outside
//
// Notes on behaviour
// - each channel alternately loads its 8-bit low and high reload values
// - counter decrements once per tick of the selected count clock
// - output level inverts on each underflow reload
// - pulse train runs continuously while run enable is set
// - three modes: independent, cascaded 16-bit, prescaler plus generator
// - mode field 00 independent, 01 prescaled, 11 cascaded
// - in independent mode channels work without depending on each other
// - each channel drives two pins, each gated by its own enable
// - counting starts once reloads are written and run is set
// - clearing run stops the counter and holds the output low
// - on underflow only the underflowing channel reloads
// - underflow sets that channel's underflow flag
// - interrupt request when flag set and interrupt enable set
// - each phase lasts reload plus one count clocks
// - cascaded mode forms one 16-bit counter with 16-bit reloads
// - three-bit clock select picks divide 1,2,4,8,16 or timebase
// - writing 0 clears a flag, writing 1 has no effect
// - cascaded underflow sets both flags together
//
// Chosen here: the plain strobed port and the register addresses.
module pulse_generator
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic timebase_tick,
    output logic ch0_pin_a,
    output logic ch0_pin_a_oe,
    output logic ch0_pin_b,
    output logic ch0_pin_b_oe,
    output logic ch1_pin_a,
    output logic ch1_pin_a_oe,
    output logic ch1_pin_b,
    output logic ch1_pin_b_oe,
    output logic ch0_irq,
    output logic ch1_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] control;
    logic [7:0] out_clk;
    logic [15:0] ch0_reload;
    logic [15:0] ch1_reload;
    logic ch0_underflow_flag;
    logic ch1_underflow_flag;
    logic [pulse_gen_pkg::prescale_width-1:0] prescale;

    logic ch0_run_enable;
    logic ch1_run_enable;
    logic ch0_underflow_irq_enable;
    logic ch1_underflow_irq_enable;
    logic ch0_pin_a_out_enable;
    logic ch1_pin_a_out_enable;
    logic ch0_pin_b_out_enable;
    logic ch1_pin_b_out_enable;
    logic [2:0] ch0_clock_select;
    logic [2:0] ch1_clock_select;
    pulse_gen_pkg::mode_t mode;

    assign ch0_run_enable = control[pulse_gen_pkg::bit_ch0_run];
    assign ch1_run_enable = control[pulse_gen_pkg::bit_ch1_run];
    assign ch0_underflow_irq_enable = control[pulse_gen_pkg::bit_ch0_irq_en];
    assign ch1_underflow_irq_enable = control[pulse_gen_pkg::bit_ch1_irq_en];
    assign ch0_pin_a_out_enable = control[pulse_gen_pkg::bit_ch0_pin_a_en];
    assign ch1_pin_a_out_enable = control[pulse_gen_pkg::bit_ch1_pin_a_en];
    assign ch0_pin_b_out_enable = out_clk[pulse_gen_pkg::bit_ch0_pin_b_en];
    assign ch1_pin_b_out_enable = out_clk[pulse_gen_pkg::bit_ch1_pin_b_en];
    assign ch0_clock_select = out_clk[pulse_gen_pkg::pos_ch0_clk_sel +: 3];
    assign ch1_clock_select = out_clk[pulse_gen_pkg::pos_ch1_clk_sel +: 3];
    assign mode = pulse_gen_pkg::mode_t'(
        control[pulse_gen_pkg::bit_mode_hi:pulse_gen_pkg::bit_mode_lo]);

    logic wr_control;
    assign wr_control = reg_write && reg_addr == pulse_gen_pkg::addr_control;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            control <= pulse_gen_pkg::control_reset;
        else if (wr_control)
            control <= reg_wdata;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            out_clk <= pulse_gen_pkg::out_clk_reset;
        else if (reg_write && reg_addr == pulse_gen_pkg::addr_out_clk)
            out_clk <= reg_wdata[7:0];
    end

    // low byte holds the low-phase reload, high byte the high-phase reload
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ch0_reload <= pulse_gen_pkg::reload_reset;
            ch1_reload <= pulse_gen_pkg::reload_reset;
        end
        else if (reg_write)
        begin
            if (reg_addr == pulse_gen_pkg::addr_ch0_reload)
                ch0_reload <= reg_wdata;
            if (reg_addr == pulse_gen_pkg::addr_ch1_reload)
                ch1_reload <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // count clock
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    logic ch0_tick;
    logic ch1_tick;

    count_clock_select u_clk0
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .prescale(prescale),
        .timebase_tick(timebase_tick),
        .clk_sel(ch0_clock_select),
        .tick(ch0_tick)
    );

    // channel 1 select takes effect in independent and reserved modes
    count_clock_select u_clk1
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .prescale(prescale),
        .timebase_tick(timebase_tick),
        .clk_sel(ch1_clock_select),
        .tick(ch1_tick)
    );

    // ------------------------------------------------------------
    // 8-bit channels (independent, prescaled and reserved modes)
    // ------------------------------------------------------------
    logic ch0_level;
    logic ch1_level;
    logic ch0_uf;
    logic ch1_uf;
    logic ch1_tick_sel;
    logic [7:0] ch0_count;
    logic [7:0] ch1_count;
    logic split_mode;
    logic cascade_mode;

    assign cascade_mode = mode == pulse_gen_pkg::mode_cascaded;
    assign split_mode = !cascade_mode;

    // prescaled mode: channel 1 counts on channel 0 underflows
    always_comb
    begin
        unique case (mode)
            pulse_gen_pkg::mode_prescaled: ch1_tick_sel = ch0_uf;
            default: ch1_tick_sel = ch1_tick;
        endcase
    end

    pulse_channel u_ch0
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(ch0_run_enable && split_mode),
        .tick(ch0_tick),
        .low_reload(ch0_reload[7:0]),
        .high_reload(ch0_reload[15:8]),
        .count(ch0_count),
        .level(ch0_level),
        .underflow(ch0_uf)
    );

    pulse_channel u_ch1
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(ch1_run_enable && split_mode),
        .tick(ch1_tick_sel),
        .low_reload(ch1_reload[7:0]),
        .high_reload(ch1_reload[15:8]),
        .count(ch1_count),
        .level(ch1_level),
        .underflow(ch1_uf)
    );

    // ------------------------------------------------------------
    // cascaded 16-bit channel
    // ------------------------------------------------------------
    logic [15:0] wide_count;
    logic wide_level;
    logic wide_running;
    logic wide_run;
    logic wide_uf;
    logic [15:0] wide_low;
    logic [15:0] wide_high;

    assign wide_run = cascade_mode && ch0_run_enable && ch1_run_enable;
    assign wide_low = {ch1_reload[7:0], ch0_reload[7:0]};
    assign wide_high = {ch1_reload[15:8], ch0_reload[15:8]};
    assign wide_uf = wide_run && wide_running && ch0_tick && wide_count == 16'h0000;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wide_count <= 16'h0000;
            wide_level <= 1'b0;
            wide_running <= 1'b0;
        end
        else if (!wide_run)
        begin
            wide_count <= 16'h0000;
            wide_level <= 1'b0;
            wide_running <= 1'b0;
        end
        else if (!wide_running)
        begin
            wide_count <= wide_low;
            wide_level <= 1'b0;
            wide_running <= 1'b1;
        end
        else if (wide_uf)
        begin
            wide_count <= wide_level ? wide_low : wide_high;
            wide_level <= ~wide_level;
        end
        else if (ch0_tick)
            wide_count <= wide_count - 16'h0001;
    end

    // ------------------------------------------------------------
    // underflow flags and interrupts
    // ------------------------------------------------------------
    logic ch0_set;
    logic ch1_set;
    logic ch0_clr;
    logic ch1_clr;

    assign ch0_set = cascade_mode ? wide_uf : ch0_uf;
    assign ch1_set = cascade_mode ? wide_uf : ch1_uf;
    assign ch0_clr = wr_control && !reg_wdata[pulse_gen_pkg::bit_ch0_flag];
    assign ch1_clr = wr_control && !reg_wdata[pulse_gen_pkg::bit_ch1_flag];

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ch0_underflow_flag <= 1'b0;
        else if (ch0_set)
            ch0_underflow_flag <= 1'b1;
        else if (ch0_clr)
            ch0_underflow_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ch1_underflow_flag <= 1'b0;
        else if (ch1_set)
            ch1_underflow_flag <= 1'b1;
        else if (ch1_clr)
            ch1_underflow_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ch0_irq <= 1'b0;
            ch1_irq <= 1'b0;
        end
        else
        begin
            ch0_irq <= ch0_underflow_flag && ch0_underflow_irq_enable;
            ch1_irq <= ch1_underflow_flag && ch1_underflow_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic out0;
    logic out1;

    assign out0 = cascade_mode ? wide_level : ch0_level;
    assign out1 = cascade_mode ? wide_level : ch1_level;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ch0_pin_a <= 1'b0;
            ch0_pin_b <= 1'b0;
            ch1_pin_a <= 1'b0;
            ch1_pin_b <= 1'b0;
        end
        else
        begin
            ch0_pin_a <= out0;
            ch0_pin_b <= out0;
            ch1_pin_a <= out1;
            ch1_pin_b <= out1;
        end
    end

    assign ch0_pin_a_oe = ch0_pin_a_out_enable;
    assign ch0_pin_b_oe = ch0_pin_b_out_enable;
    assign ch1_pin_a_oe = ch1_pin_a_out_enable;
    assign ch1_pin_b_oe = ch1_pin_b_out_enable;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] next_rdata;

    always_comb
    begin
        next_rdata = 16'h0000;
        unique case (reg_addr)
            pulse_gen_pkg::addr_control:
            begin
                next_rdata = control;
                next_rdata[pulse_gen_pkg::bit_ch0_flag] = ch0_underflow_flag;
                next_rdata[pulse_gen_pkg::bit_ch1_flag] = ch1_underflow_flag;
            end
            pulse_gen_pkg::addr_ch0_reload: next_rdata = ch0_reload;
            pulse_gen_pkg::addr_ch1_reload: next_rdata = ch1_reload;
            pulse_gen_pkg::addr_out_clk: next_rdata = {8'h00, out_clk};
            pulse_gen_pkg::addr_counters:
                next_rdata = cascade_mode ? wide_count : {ch1_count, ch0_count};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else if (reg_read)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 16'h0000;
    end
endmodule
